/* pkg/fhb_consts.svh */
`ifndef FHB_CONSTS_SVH
`define FHB_CONSTS_SVH
// array geometry
`define FHB_AW 21
`define FHB_DW 16
`define FHB_NBLK 71
`define FHB_PARAM_BLKS 8
`define FHB_MAIN_LO 15
`define FHB_PARAM_LO 12
`define FHB_BANK_LO 18
// command codes
`define FHB_CMD_PROG 8'h40
`define FHB_CMD_PROG_ALT 8'h10
`define FHB_CMD_LOCK_SETUP 8'h60
`define FHB_CMD_LOCK 8'h01
`define FHB_CMD_LOCKDOWN 8'h2F
`define FHB_CMD_UNLOCK 8'hD0
`define FHB_CMD_SET_CFG 8'h03
`define FHB_CMD_READ_STATUS 8'h70
`define FHB_CMD_CLR_STATUS 8'h50
`define FHB_CMD_READ_ARRAY 8'hFF
// configuration register fields and reset value
`define FHB_CFG_RESET 16'hFFFF
`define FHB_CFG_ASYNC_BIT 15
`define FHB_CFG_LAT_HI 13
`define FHB_CFG_LAT_LO 11
`define FHB_CFG_WAIT_POL_BIT 10
`define FHB_CFG_WAIT_ADV_BIT 8
`define FHB_CFG_RISE_BIT 6
// status register fields
`define FHB_SR_READY_BIT 7
`define FHB_SR_PROG_ERR_BIT 4
`define FHB_SR_VPP_ERR_BIT 3
`define FHB_SR_LOCK_ERR_BIT 1
// timing
`define FHB_CLK_PERIOD_NS 10
`define FHB_PROG_TIME_NS 1000
`define FHB_PROG_CYCLES \
  ((`FHB_PROG_TIME_NS + `FHB_CLK_PERIOD_NS - 1) / `FHB_CLK_PERIOD_NS)
`endif

/* pkg/fhb_pkg.sv */
`default_nettype none
`include "fhb_consts.svh"
package fhb_pkg;
  typedef logic [`FHB_AW-1:0] fhb_addr_t;
  typedef logic [`FHB_DW-1:0] fhb_word_t;
  typedef logic [6:0] fhb_blk_t;
  // bus strobes, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_drive_n;
    logic write_n;
    logic latch_n;
    logic hard_init_n;
    logic guard_n;
  } fhb_ctl_s;
  typedef enum logic [4:0] {
    FHB_CI_READ = 5'h01,
    FHB_CI_STATUS = 5'h02,
    FHB_CI_PROG = 5'h04,
    FHB_CI_LOCK = 5'h08,
    FHB_CI_BUSY = 5'h10
  } fhb_ci_e;
  typedef enum logic [2:0] {
    FHB_PWR_ACTIVE = 3'h1,
    FHB_PWR_STANDBY = 3'h2,
    FHB_PWR_RESET = 3'h4
  } fhb_pwr_e;
endpackage
`default_nettype wire

/* src/fhb_mem.sv */
`default_nettype none
`include "fhb_consts.svh"
module fhb_mem (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic wr_en_in,
  input wire fhb_pkg::fhb_addr_t wr_addr_in,
  input wire fhb_pkg::fhb_word_t wr_data_in,
  input wire fhb_pkg::fhb_addr_t rd_addr_in,
  output fhb_pkg::fhb_word_t rd_data_out
);
  import fhb_pkg::*;
  fhb_word_t mem_q [0:(1 << `FHB_AW) - 1];

  // array ships erased
  initial begin
    for (int i = 0; i < (1 << `FHB_AW); i++) begin
      mem_q[i] = 16'hFFFF;
    end
  end

  always_ff @(posedge clk_in) begin
    if (en_in && wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (en_in) begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

/* src/fhb_bus_core.sv */
`default_nettype none
`include "fhb_consts.svh"
module fhb_bus_core (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic burst_clk_in,
  input wire fhb_pkg::fhb_ctl_s ctl_in,
  input wire fhb_pkg::fhb_addr_t word_address_bus_in,
  input wire fhb_pkg::fhb_word_t bidir_data_bus_in,
  input wire logic vpp_over_program_enable_threshold_in,
  input wire logic vpp_under_program_lockout_threshold_in,
  output fhb_pkg::fhb_word_t bidir_data_bus_out,
  output logic bidir_data_bus_oe_out,
  output logic wait_out,
  output logic wait_oe_out,
  output fhb_pkg::fhb_pwr_e power_mode_out,
  output logic busy_out
);
  import fhb_pkg::*;

  function automatic fhb_blk_t blk_of(input fhb_addr_t a);
    if (a[`FHB_AW-1:`FHB_MAIN_LO] == 6'h00) begin
      blk_of = {4'h0, a[`FHB_MAIN_LO-1:`FHB_PARAM_LO]};
    end else begin
      blk_of = 7'(a[`FHB_AW-1:`FHB_MAIN_LO]) + 7'(`FHB_PARAM_BLKS - 1);
    end
  endfunction

  function automatic logic [2:0] bank_of(input fhb_addr_t a);
    bank_of = a[`FHB_AW-1:`FHB_BANK_LO];
  endfunction

  function automatic fhb_addr_t gray2bin(input fhb_addr_t g);
    fhb_addr_t b;
    b[`FHB_AW-1] = g[`FHB_AW-1];
    for (int i = `FHB_AW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, system clock
  fhb_ctl_s ctl_m, ctl_s, ctl_p;
  fhb_addr_t addr_m, addr_s;
  fhb_word_t data_m, data_s;
  logic [1:0] vpp_m, vpp_s;

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      ctl_m <= ctl_in;
      ctl_s <= ctl_m;
      ctl_p <= ctl_s;
      addr_m <= word_address_bus_in;
      addr_s <= addr_m;
      data_m <= bidir_data_bus_in;
      data_s <= data_m;
      vpp_m <= {vpp_under_program_lockout_threshold_in,
                vpp_over_program_enable_threshold_in};
      vpp_s <= vpp_m;
    end
  end

  logic hard_rst;
  logic active;
  logic vpp_ok;
  assign hard_rst = sys_rst_in | ~ctl_s.hard_init_n;
  assign active = ~ctl_s.chip_sel_n & ctl_s.hard_init_n;
  assign vpp_ok = vpp_s[0] & ~vpp_s[1];

  ////////////////////////////////////////////////////////////////////////
  // address latch and write capture
  fhb_addr_t lat_addr_q, wr_addr_q;
  fhb_word_t wr_data_q;
  logic wr_act_q, cmd_stb_q, wr_phase;
  assign wr_phase = active & ~ctl_s.write_n & ctl_s.out_drive_n;

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        lat_addr_q <= '0;
      end else if (~ctl_s.latch_n) begin
        lat_addr_q <= addr_s;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        wr_act_q <= 1'b0;
        cmd_stb_q <= 1'b0;
        wr_addr_q <= '0;
        wr_data_q <= '0;
      end else begin
        wr_act_q <= wr_phase;
        // first strobe to rise ends the phase; last sampled values stand
        cmd_stb_q <= wr_act_q & ~wr_phase;
        if (wr_phase) begin
          wr_addr_q <= lat_addr_q;
          wr_data_q <= data_s;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  fhb_ci_e ci_q;
  logic [70:0] lock_q, lockdown_q;
  logic [15:0] cfg_q, busy_cnt_q;
  logic [7:0] sr_q;
  fhb_addr_t prog_addr_q;
  fhb_word_t prog_data_q;
  logic [7:0] code;
  fhb_blk_t blk;
  logic lock_go, lock_refused, prog_go, prog_ok, mem_wr, clr_sr;
  assign code = wr_data_q[7:0];
  assign blk = blk_of(wr_addr_q);
  assign lock_go = cmd_stb_q & (ci_q == FHB_CI_LOCK);
  assign lock_refused = lock_go & lockdown_q[blk] & ~ctl_s.guard_n;
  assign prog_go = cmd_stb_q & (ci_q == FHB_CI_PROG);
  assign prog_ok = vpp_ok & ~lock_q[blk];
  assign mem_wr = (ci_q == FHB_CI_BUSY) & (busy_cnt_q == 16'h0001);
  assign clr_sr = cmd_stb_q & (ci_q == FHB_CI_READ || ci_q == FHB_CI_STATUS)
    & (code == `FHB_CMD_CLR_STATUS);

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        ci_q <= FHB_CI_READ;
        busy_cnt_q <= '0;
        prog_addr_q <= '0;
        prog_data_q <= '0;
      end else begin
        case (ci_q)
          FHB_CI_READ, FHB_CI_STATUS: begin
            if (cmd_stb_q) begin
              if (code == `FHB_CMD_PROG || code == `FHB_CMD_PROG_ALT) begin
                ci_q <= FHB_CI_PROG;
              end else if (code == `FHB_CMD_LOCK_SETUP) begin
                ci_q <= FHB_CI_LOCK;
              end else if (code == `FHB_CMD_READ_STATUS) begin
                ci_q <= FHB_CI_STATUS;
              end else if (code == `FHB_CMD_READ_ARRAY) begin
                ci_q <= FHB_CI_READ;
              end
            end
          end
          FHB_CI_PROG: begin
            if (prog_go) begin
              if (prog_ok) begin
                prog_addr_q <= wr_addr_q;
                prog_data_q <= wr_data_q;
                busy_cnt_q <= 16'(`FHB_PROG_CYCLES);
                ci_q <= FHB_CI_BUSY;
              end else begin
                ci_q <= FHB_CI_STATUS;
              end
            end
          end
          FHB_CI_LOCK: begin
            if (lock_go) begin
              if (code == `FHB_CMD_SET_CFG) begin
                ci_q <= FHB_CI_READ;
              end else if (lock_refused) begin
                ci_q <= FHB_CI_STATUS;
              end else if (code == `FHB_CMD_LOCK
                  || code == `FHB_CMD_LOCKDOWN
                  || code == `FHB_CMD_UNLOCK) begin
                ci_q <= FHB_CI_READ;
              end else begin
                ci_q <= FHB_CI_STATUS;
              end
            end
          end
          FHB_CI_BUSY: begin
            // voltage already sampled; later changes do not matter
            busy_cnt_q <= busy_cnt_q - 16'h0001;
            if (busy_cnt_q == 16'h0001) begin
              ci_q <= FHB_CI_STATUS;
            end
          end
          default: begin
            ci_q <= FHB_CI_READ;
          end
        endcase
      end
    end
  end

  // block protection
  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        lock_q <= '1;
        lockdown_q <= '0;
      end else if (lock_go && !lock_refused) begin
        if (code == `FHB_CMD_LOCK) begin
          lock_q[blk] <= 1'b1;
        end else if (code == `FHB_CMD_UNLOCK) begin
          lock_q[blk] <= 1'b0;
        end else if (code == `FHB_CMD_LOCKDOWN) begin
          lock_q[blk] <= 1'b1;
          lockdown_q[blk] <= 1'b1;
        end
      end
    end
  end

  // configuration, data taken from the address bus
  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        cfg_q <= `FHB_CFG_RESET;
      end else if (lock_go && code == `FHB_CMD_SET_CFG) begin
        cfg_q <= wr_addr_q[15:0];
      end
    end
  end

  // status: a new error wins over a clear in the same cycle
  logic [7:0] sr_set;
  always_comb begin
    sr_set = 8'h00;
    sr_set[`FHB_SR_VPP_ERR_BIT] = prog_go & ~vpp_ok;
    sr_set[`FHB_SR_PROG_ERR_BIT] = prog_go & vpp_ok & lock_q[blk];
    sr_set[`FHB_SR_LOCK_ERR_BIT] = lock_refused;
  end

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        sr_q <= 8'h00;
      end else begin
        sr_q <= ((clr_sr ? 8'h00 : sr_q) | sr_set);
        sr_q[`FHB_SR_READY_BIT] <= (ci_q != FHB_CI_BUSY) | mem_wr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst clock domain
  logic kr_m, kr_s, ke_m, ke_s, ks_m, ks_s;
  logic [5:0] kc_m, kc_s;
  logic sync_lvl_q, neg_hit_q, run_q, tog_q, wait_k_q;
  fhb_addr_t neg_addr_q, base_q, off_q, off_gray_q;
  logic [2:0] lat_cnt_q;
  logic start;
  fhb_addr_t start_addr;

  always_ff @(posedge burst_clk_in) begin
    kr_m <= ctl_in.hard_init_n;
    kr_s <= kr_m;
    ke_m <= clk_en_in;
    ke_s <= ke_m;
    ks_m <= sync_lvl_q;
    ks_s <= ks_m;
    kc_m <= {cfg_q[`FHB_CFG_RISE_BIT], cfg_q[`FHB_CFG_WAIT_ADV_BIT],
             cfg_q[`FHB_CFG_LAT_HI:`FHB_CFG_LAT_LO], 1'b0};
    kc_s <= kc_m;
  end

  always_ff @(negedge burst_clk_in) begin
    neg_hit_q <= ~ctl_in.latch_n & ~ctl_in.chip_sel_n;
    neg_addr_q <= word_address_bus_in;
  end

  assign start = kc_s[5] ? (~ctl_in.latch_n & ~ctl_in.chip_sel_n)
    : neg_hit_q;
  assign start_addr = kc_s[5] ? word_address_bus_in : neg_addr_q;

  always_ff @(posedge burst_clk_in) begin
    if (!kr_s || !ks_s) begin
      run_q <= 1'b0;
      lat_cnt_q <= 3'h0;
      off_q <= '0;
      off_gray_q <= '0;
      wait_k_q <= 1'b0;
      tog_q <= 1'b0;
      base_q <= '0;
    end else if (ke_s) begin
      if (start) begin
        base_q <= start_addr;
        tog_q <= ~tog_q;
        lat_cnt_q <= kc_s[3:1];
        off_q <= '0;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (lat_cnt_q != 3'h0) begin
          lat_cnt_q <= lat_cnt_q - 3'h1;
        end else begin
          off_q <= off_q + 21'h000001;
        end
      end
      off_gray_q <= off_q ^ (off_q >> 1);
      wait_k_q <= run_q & (kc_s[4] ? (lat_cnt_q > 3'h1)
        : (lat_cnt_q != 3'h0));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing back into the system clock
  logic kt_m, kt_s, kt_p, wk_m, wk_s;
  fhb_addr_t og_m, og_s, burst_base_q, burst_addr;
  logic sync_mode;
  assign sync_mode = ~cfg_q[`FHB_CFG_ASYNC_BIT];

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      kt_m <= tog_q;
      kt_s <= kt_m;
      kt_p <= kt_s;
      og_m <= off_gray_q;
      og_s <= og_m;
      wk_m <= wait_k_q;
      wk_s <= wk_m;
    end
  end

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        sync_lvl_q <= 1'b0;
        burst_base_q <= '0;
      end else begin
        sync_lvl_q <= sync_mode & active & ctl_s.write_n;
        if (kt_s != kt_p) begin
          burst_base_q <= base_q;
        end
      end
    end
  end
  assign burst_addr = burst_base_q + gray2bin(og_s);

  ////////////////////////////////////////////////////////////////////////
  // array read path and pins
  fhb_addr_t rd_addr;
  fhb_word_t mem_rd;
  logic show_sr_q, armed_q;
  assign rd_addr = sync_mode ? burst_addr : lat_addr_q;

  fhb_mem i_fhb_mem (
    .clk_in(clk_in),
    .en_in(clk_en_in),
    .wr_en_in(mem_wr),
    .wr_addr_in(prog_addr_q),
    .wr_data_in(prog_data_q),
    .rd_addr_in(rd_addr),
    .rd_data_out(mem_rd)
  );

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        show_sr_q <= 1'b0;
        armed_q <= 1'b0;
      end else begin
        // busy bank answers with status, other banks read the array
        show_sr_q <= (ci_q == FHB_CI_STATUS) || ((ci_q == FHB_CI_BUSY)
          && bank_of(rd_addr) == bank_of(prog_addr_q));
        if ((ctl_p.chip_sel_n && !ctl_s.chip_sel_n)
            || (ctl_p.latch_n && !ctl_s.latch_n)) begin
          armed_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (clk_en_in) begin
      if (hard_rst) begin
        bidir_data_bus_out <= '0;
        bidir_data_bus_oe_out <= 1'b0;
        wait_out <= 1'b0;
        wait_oe_out <= 1'b0;
        power_mode_out <= FHB_PWR_RESET;
        busy_out <= 1'b0;
      end else begin
        bidir_data_bus_out <= show_sr_q ? {8'h00, sr_q} : mem_rd;
        bidir_data_bus_oe_out <= active & ~ctl_s.out_drive_n
          & ctl_s.write_n & armed_q;
        wait_out <= (sync_mode & wk_s) ^ ~cfg_q[`FHB_CFG_WAIT_POL_BIT];
        wait_oe_out <= active;
        power_mode_out <= active ? FHB_PWR_ACTIVE : FHB_PWR_STANDBY;
        busy_out <= (ci_q == FHB_CI_BUSY);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/fhb_bus_core_sva.sv */
`default_nettype none
`include "fhb_consts.svh"
module fhb_bus_core_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic burst_clk_in,
  input wire fhb_pkg::fhb_ctl_s ctl_in,
  input wire fhb_pkg::fhb_addr_t word_address_bus_in,
  input wire fhb_pkg::fhb_word_t bidir_data_bus_in,
  input wire logic vpp_over_program_enable_threshold_in,
  input wire logic vpp_under_program_lockout_threshold_in,
  input wire fhb_pkg::fhb_word_t bidir_data_bus_out,
  input wire logic bidir_data_bus_oe_out,
  input wire logic wait_out,
  input wire logic wait_oe_out,
  input wire fhb_pkg::fhb_pwr_e power_mode_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import fhb_pkg::*;
  localparam int PROG = `FHB_PROG_CYCLES;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic cs_n;
  logic init_n;
  logic armed_q;
  logic [3:0] init_lo_q;
  logic [7:0] busy_cnt_q;
  assign cs_n = ctl_in.chip_sel_n;
  assign init_n = ctl_in.hard_init_n;
  // reset pin low history
  always_ff @(posedge clk_in) begin
    init_lo_q <= {init_lo_q[2:0], ~init_n};
  end
  // output arming after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || init_lo_q == 4'hF) begin
      armed_q <= 1'b0;
    end else if ($fell(cs_n) || $fell(ctl_in.latch_n)) begin
      armed_q <= 1'b1;
    end
  end
  // program length
  always_ff @(posedge clk_in) begin
    if (!busy_out) begin
      busy_cnt_q <= 8'h00;
    end else if (clk_en_in) begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end
  end
  a_rst_quiet: assert property (disable iff (1'b0)
    sys_rst_in && clk_en_in |=> !bidir_data_bus_oe_out && !wait_oe_out
    && !busy_out && power_mode_out == FHB_PWR_RESET)
    else $error("outputs active in reset");
  a_desel_float: assert property ((cs_n && clk_en_in)[*6]
    |-> !bidir_data_bus_oe_out) else $error("data driven while deselected");
  a_desel_wait: assert property ((cs_n && clk_en_in)[*6]
    |-> !wait_oe_out) else $error("wait driven while deselected");
  a_init_float: assert property ((!init_n && clk_en_in)[*6]
    |-> !bidir_data_bus_oe_out && !wait_oe_out
    && power_mode_out == FHB_PWR_RESET) else $error("reset pin ignored");
  a_standby_mode: assert property (
    (cs_n && init_n && !busy_out && clk_en_in)[*6]
    |-> power_mode_out == FHB_PWR_STANDBY) else $error("no standby");
  a_active_mode: assert property ((!cs_n && init_n && clk_en_in)[*6]
    |-> power_mode_out == FHB_PWR_ACTIVE) else $error("not active");
  a_drive_gate: assert property ((ctl_in.out_drive_n && clk_en_in)[*6]
    |-> !bidir_data_bus_oe_out) else $error("data driven without strobe");
  a_arm_first: assert property (!armed_q |-> !bidir_data_bus_oe_out)
    else $error("data driven before arming edge");
  a_prog_hold: assert property ($fell(busy_out) && init_lo_q == 4'h0
    |-> int'(busy_cnt_q) >= PROG - 1 && int'(busy_cnt_q) <= PROG + 1)
    else $error("program length wrong");
  c_busy: cover property ($rose(busy_out));
  c_read: cover property ($rose(bidir_data_bus_oe_out));
  c_wait: cover property ($rose(wait_oe_out));
endmodule
`default_nettype wire

/* verification/fhb_host_model.sv */
`default_nettype none
module fhb_host_model (
  input wire logic clk_in,
  input wire fhb_pkg::fhb_word_t bus_in,
  input wire logic oe_in,
  input wire logic wait_in,
  input wire logic wait_oe_in,
  output fhb_pkg::fhb_ctl_s ctl_out,
  output fhb_pkg::fhb_addr_t addr_out,
  output fhb_pkg::fhb_word_t data_out,
  output logic drv_out,
  output logic burst_clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import fhb_pkg::*;
  logic saw_wait_act;
  logic saw_wait_idle;
  initial begin
    ctl_out = 6'h0F;
    addr_out = '0;
    data_out = '0;
    drv_out = 1'b0;
    burst_clk_out = 1'b0;
  end
  // drive pins at an edge, hold five cycles
  task automatic drive(input fhb_ctl_s c, input fhb_addr_t a,
                       input fhb_word_t d, input logic dv);
    ctl_out <= c;
    addr_out <= a;
    data_out <= d;
    drv_out <= dv;
    repeat (5) @(posedge clk_in);
  endtask
  task automatic set_ctl(input fhb_ctl_s c);
    drive(c, addr_out, data_out, 1'b0);
  endtask
  task automatic bus_write(input fhb_addr_t a, input fhb_word_t d,
                           input bit cs_first);
    fhb_ctl_s c;
    c = ctl_out;
    c.latch_n = 1'b0;
    c.chip_sel_n = 1'b0;
    c.write_n = 1'b0;
    c.out_drive_n = 1'b1;
    drive(c, a, d, 1'b1);
    if (cs_first) c.chip_sel_n = 1'b1;
    else c.write_n = 1'b1;
    drive(c, ~a, ~d, 1'b1);
    c.chip_sel_n = 1'b1;
    c.write_n = 1'b1;
    drive(c, a, d, 1'b0);
  endtask
  task automatic bus_read(input fhb_addr_t a, output fhb_word_t d);
    fhb_ctl_s c;
    int n;
    c = ctl_out;
    c.chip_sel_n = 1'b1;
    c.out_drive_n = 1'b1;
    drive(c, a, data_out, 1'b0);
    c.chip_sel_n = 1'b0;
    c.out_drive_n = 1'b0;
    c.latch_n = 1'b0;
    ctl_out <= c;
    n = 0;
    while (oe_in !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    repeat (7) @(posedge clk_in);
    d = bus_in;
    c.chip_sel_n = 1'b1;
    c.out_drive_n = 1'b1;
    drive(c, a, data_out, 1'b0);
  endtask
  // burst clock runs only inside the frame
  task automatic burst(input fhb_addr_t a, input int n);
    fhb_ctl_s c;
    c = ctl_out;
    c.chip_sel_n = 1'b0;
    c.out_drive_n = 1'b0;
    c.latch_n = 1'b0;
    drive(c, a, data_out, 1'b0);
    saw_wait_act = 1'b0;
    saw_wait_idle = 1'b0;
    fork
      repeat (n) begin
        #7.5 burst_clk_out = 1'b1;
        #7.5 burst_clk_out = 1'b0;
        if (wait_oe_in && wait_in) saw_wait_act = 1'b1;
        if (wait_oe_in && !wait_in && saw_wait_act) saw_wait_idle = 1'b1;
      end
      begin
        // burst-side synchronisers need a few edges before the start
        #60;
        @(posedge clk_in);
        ctl_out.latch_n <= 1'b1;
      end
    join
    @(posedge clk_in);
    c.chip_sel_n = 1'b1;
    c.out_drive_n = 1'b1;
    drive(c, a, data_out, 1'b0);
  endtask
endmodule
`default_nettype wire

/* verification/fhb_bus_core_tb.sv */
`default_nettype none
`include "fhb_consts.svh"
`define FHB_CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module fhb_bus_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fhb_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en = 1'b1;
  logic vpp_en = 1'b1;
  logic vpp_lo = 1'b0;
  fhb_ctl_s ctl;
  fhb_ctl_s c;
  fhb_addr_t addr, a_a, a_b, a_c;
  fhb_word_t h_data, d_data, bus_w, rd, w_a, w_b, cfg;
  fhb_word_t alt_q = 16'h5AA5;
  logic h_drv, d_oe, w_out, w_oe, wait_w, bclk, busy;
  fhb_pwr_e pmode;
  int bad_count = 0;
  int comparisons = 0;
  int seed;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) alt_q <= ~alt_q;
  assign bus_w = h_drv ? h_data : (d_oe ? d_data : alt_q);
  assign wait_w = w_oe ? w_out : alt_q[0];
  fhb_bus_core i_fhb_bus_core (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en), .burst_clk_in(bclk), .ctl_in(ctl),
    .word_address_bus_in(addr), .bidir_data_bus_in(bus_w),
    .vpp_over_program_enable_threshold_in(vpp_en),
    .vpp_under_program_lockout_threshold_in(vpp_lo),
    .bidir_data_bus_out(d_data), .bidir_data_bus_oe_out(d_oe),
    .wait_out(w_out), .wait_oe_out(w_oe), .power_mode_out(pmode),
    .busy_out(busy));
  fhb_host_model i_fhb_host_model (.clk_in(clk_in), .bus_in(bus_w),
    .oe_in(d_oe), .wait_in(wait_w), .wait_oe_in(w_oe), .ctl_out(ctl),
    .addr_out(addr), .data_out(h_data), .drv_out(h_drv),
    .burst_clk_out(bclk));
  ////////////////////////////////////////////////////////////////////////////
  function automatic fhb_word_t stat_exp(input logic [7:0] err);
    return {8'h00, 8'h80 | err};
  endfunction
  task automatic cmd(input fhb_addr_t a, input logic [7:0] op);
    i_fhb_host_model.bus_write(a, {8'h00, op}, 1'($urandom_range(1)));
  endtask
  task automatic status_is(input logic [7:0] err);
    cmd(a_a, `FHB_CMD_READ_STATUS);
    i_fhb_host_model.bus_read(a_a, rd);
    `FHB_CHK(rd, stat_exp(err))
    cmd(a_a, `FHB_CMD_CLR_STATUS);
  endtask
  task automatic prog(input fhb_addr_t a, input fhb_word_t d);
    cmd(a, `FHB_CMD_PROG);
    i_fhb_host_model.bus_write(a, d, 1'($urandom_range(1)));
  endtask
  task automatic lock_op(input fhb_addr_t a, input logic [7:0] op);
    cmd(a, `FHB_CMD_LOCK_SETUP);
    cmd(a, op);
  endtask
  task automatic pin(input int idx, input logic v);
    c = ctl;
    c[idx] = v;
    i_fhb_host_model.set_ctl(c);
  endtask
  task automatic wait_busy();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    finish_test();
  end
  initial begin
    seed = $urandom(91);
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    `FHB_CHK(d_oe, 1'b0)
    `FHB_CHK(pmode, FHB_PWR_ACTIVE)
    pin(5, 1'b1);
    `FHB_CHK(pmode, FHB_PWR_STANDBY)
    clk_en <= 1'b0;
    pin(5, 1'b0);
    `FHB_CHK(pmode, FHB_PWR_STANDBY)
    clk_en <= 1'b1;
    pin(5, 1'b1);
    `FHB_CHK(pmode, FHB_PWR_STANDBY)
    a_a = {3'h1 + 3'($urandom_range(6)), 18'($urandom)};
    a_b = a_a ^ 21'h008000;
    a_c = a_a ^ 21'h040000;
    w_a = 16'($urandom);
    w_b = ~w_a;
    prog(a_a, w_a);
    status_is(8'h01 << `FHB_SR_PROG_ERR_BIT);
    lock_op(a_a, `FHB_CMD_UNLOCK);
    lock_op(a_c, `FHB_CMD_UNLOCK);
    prog(a_c, w_b);
    wait_busy();
    vpp_lo <= 1'b1;
    vpp_en <= 1'b0;
    prog(a_a, w_a);
    status_is(8'h01 << `FHB_SR_VPP_ERR_BIT);
    vpp_lo <= 1'b0;
    vpp_en <= 1'b1;
    prog(a_a, w_a);
    repeat (3) @(posedge clk_in);
    `FHB_CHK(busy, 1'b1)
    vpp_lo <= 1'b1;
    vpp_en <= 1'b0;
    i_fhb_host_model.bus_read(a_c, rd);
    `FHB_CHK(rd, w_b)
    i_fhb_host_model.bus_read(a_a, rd);
    `FHB_CHK(rd, 16'h0000)
    wait_busy();
    vpp_lo <= 1'b0;
    vpp_en <= 1'b1;
    status_is(8'h00);
    cmd(a_a, `FHB_CMD_READ_ARRAY);
    i_fhb_host_model.bus_read(a_a, rd);
    `FHB_CHK(rd, w_a)
    lock_op(a_b, `FHB_CMD_LOCKDOWN);
    pin(0, 1'b0);
    lock_op(a_b, `FHB_CMD_UNLOCK);
    status_is(8'h01 << `FHB_SR_LOCK_ERR_BIT);
    pin(0, 1'b1);
    lock_op(a_b, `FHB_CMD_UNLOCK);
    prog(a_b, w_b);
    wait_busy();
    status_is(8'h00);
    cfg = 16'h7FFF ^ (16'($urandom_range(1)) << `FHB_CFG_WAIT_ADV_BIT);
    lock_op({a_a[20:16], cfg}, `FHB_CMD_SET_CFG);
    cmd(a_a, `FHB_CMD_READ_ARRAY);
    i_fhb_host_model.burst(a_a, 40);
    `FHB_CHK(i_fhb_host_model.saw_wait_act, 1'b1)
    `FHB_CHK(i_fhb_host_model.saw_wait_idle, 1'b1)
    `FHB_CHK(w_oe, 1'b0)
    pin(1, 1'b0);
    `FHB_CHK(pmode, FHB_PWR_RESET)
    `FHB_CHK(d_oe, 1'b0)
    pin(1, 1'b1);
    prog(a_a, w_b);
    status_is(8'h01 << `FHB_SR_PROG_ERR_BIT);
    cmd(a_a, `FHB_CMD_READ_ARRAY);
    i_fhb_host_model.bus_read(a_a, rd);
    `FHB_CHK(rd, w_a)
    finish_test();
  end
endmodule
bind fhb_bus_core fhb_bus_core_sva i_fhb_bus_core_sva (.clk_in, .sys_rst_in,
  .clk_en_in, .burst_clk_in, .ctl_in, .word_address_bus_in,
  .bidir_data_bus_in, .vpp_over_program_enable_threshold_in,
  .vpp_under_program_lockout_threshold_in, .bidir_data_bus_out,
  .bidir_data_bus_oe_out, .wait_out, .wait_oe_out, .power_mode_out,
  .busy_out);
`default_nettype wire
